// ===== io_processor_unit_defines.vh
// constants shared by the selector processor cpu port files
`ifndef IO_PROCESSOR_UNIT_DEFINES_VH
`define IO_PROCESSOR_UNIT_DEFINES_VH

// ==================================================
// apb register map (byte addresses)
`define REG_CTRL_ADDR      12'h000
`define REG_STATUS_ADDR    12'h004
`define REG_CLEAR_ADDR     12'h008
`define REG_WORD_ADDR      12'h00C

// ==================================================
// control register fields
`define CTRL_LAST_BIT      0
`define CTRL_IZC_BIT       1
`define CTRL_ICE_BIT       2
`define CTRL_IUE_BIT       3
`define CTRL_WB_BIT        4
`define CTRL_ADDR_LSB      8
`define CTRL_ADDR_MSB      10
`define CTRL_RESET         11'h000
`define CTRL_WIDTH         11

// ==================================================
// status register fields
`define STAT_BITS_LSB      0
`define STAT_BITS_MSB      4
`define STAT_PR_BIT        16
`define STAT_CC1_BIT       17
`define STAT_CC2_BIT       18
`define STAT_STATE_LSB     19
`define STAT_STATE_MSB     21
`define STAT_EDGE_LSB      24
`define STAT_EDGE_MSB      31

// ==================================================
// own status bit indices inside the sticky vector (word bits 8..12)
`define OWN_INC_LEN        0
`define OWN_XMIT_ERR       1
`define OWN_ZERO_CNT       2
`define OWN_CHAN_END       3
`define OWN_UNUSUAL        4
`define OWN_WIDTH          5
`define OWN_ZERO_PAD       3'h0

// ==================================================
// function codes, first line in the msb
`define FN_START           3'h0
`define FN_TEST            3'h1
`define FN_TEST_DEV        3'h2
`define FN_HALT            3'h3
`define FN_ACK_INT         3'h6

// ==================================================
// sequencer states
`define ST_IDLE            3'h0
`define ST_PASS            3'h1
`define ST_TERM            3'h2
`define ST_MEMRD           3'h3
`define ST_CTRL            3'h4
`define ST_MEMWR           3'h5
`define ST_SETTLE          3'h6
`define ST_PROCEED         3'h7

// ==================================================
// misc widths
`define SYNC_WIDTH         9
`define ZERO32             32'h0000_0000

`endif

// ===== pin_sync.v
// two flip-flop synchroniser bank for the cpu cable inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter W = 1
) (
	input  wire         clk_in,
	input  wire         rst_in,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// ==================================================
	// per-bit stages; the first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					meta_ff[i] <= 1'b0;
					sync_ff[i] <= 1'b0;
				end else begin
					meta_ff[i] <= async_in[i];
					sync_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_ff;
endmodule

// ===== func_decode.v
// function code and processor address decoder
`timescale 1ns/1ps
`include "io_processor_unit_defines.vh"
module func_decode (
	input  wire [2:0] func_in,
	input  wire [2:0] addr_in,
	input  wire [2:0] own_addr_in,
	input  wire       irq_in,
	output wire       start_out,
	output wire       test_out,
	output wire       tdev_out,
	output wire       halt_out,
	output wire       ack_out,
	output wire       claim_out
);
	wire addr_hit;

	// ==================================================
	// code table
	assign start_out = (func_in == `FN_START);
	assign test_out  = (func_in == `FN_TEST);
	assign tdev_out  = (func_in == `FN_TEST_DEV);
	assign halt_out  = (func_in == `FN_HALT);
	assign ack_out   = (func_in == `FN_ACK_INT);

	assign addr_hit  = (addr_in == own_addr_in);
	assign claim_out = ((start_out | test_out | tdev_out | halt_out) & addr_hit)
		| (ack_out & irq_in);
endmodule

// ===== selector_io_processor.v
// cpu instruction port of the selector io processor
`timescale 1ns/1ps
`include "io_processor_unit_defines.vh"
module selector_io_processor (
	input  wire        clk_in,
	input  wire        rst_in,
	// apb slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output wire [31:0] prdata_out,
	output wire        pready_out,
	output wire        pslverr_out,
	// cpu cable, asynchronous
	input  wire        source_clock_1mhz_in,
	input  wire        control_strobe_in,
	input  wire        func_code_bit0_in,
	input  wire        func_code_bit1_in,
	input  wire        func_code_bit2_in,
	input  wire [2:0]  processor_addr_in,
	input  wire        reset_io_in,
	output wire        interrupt_request_out,
	output wire        cond_code_one_n_out,
	output wire        cond_code_two_n_out,
	output wire        cond_code_oe_out,
	output wire        proceed_out,
	output wire        strobe_pass_out,
	// controller side and service logic, same clock
	output wire        ctrl_clock_out,
	output wire        ctrl_reset_out,
	input  wire        dc_int_req_in,
	input  wire        service_active_in,
	input  wire        partial_cond_in,
	output wire        end_service_out,
	output wire        ctrl_req_out,
	input  wire        ctrl_cc_valid_in,
	input  wire        data_order_request_in,
	input  wire        in_out_request_in,
	input  wire        dc_addr_match_in,
	input  wire [7:0]  dc_status_in,
	output wire        mem_rd_req_out,
	input  wire        mem_rd_done_in,
	input  wire        mem_parity_err_in,
	output wire        mem_wr_req_out,
	input  wire        mem_release_in,
	output wire [15:0] status_word_out,
	// status events, one-cycle pulses
	input  wire        inc_len_status_ev_in,
	input  wire        inc_len_buffer_ev_in,
	input  wire        xmit_err_ev_in,
	input  wire        zero_cnt_in_ev_in,
	input  wire        zero_cnt_out_ev_in,
	input  wire        chan_end_ev_in,
	input  wire        halt_terminal_ev_in
);
	// ==================================================
	// declarations
	wire [`SYNC_WIDTH-1:0] raw_pins;
	wire [`SYNC_WIDTH-1:0] sync_pins;
	wire                   srcclk_s;
	wire                   strobe_s;
	wire [2:0]             func_s;
	wire [2:0]             addr_s;
	wire                   rio_s;
	wire                   is_start;
	wire                   is_test;
	wire                   is_tdev;
	wire                   is_halt;
	wire                   is_ack;
	wire                   claim;
	wire                   wr_en;
	wire                   rd_en;
	wire                   addr_ok;
	wire                   clr_wr;
	wire [`OWN_WIDTH-1:0]  set_ev;
	wire [`OWN_WIDTH-1:0]  clr_bits;
	wire [`OWN_WIDTH-1:0]  hio_clr;
	wire [2:0]             own_addr;

	reg  [`CTRL_WIDTH-1:0] ctrl_ff;
	reg  [`OWN_WIDTH-1:0]  own_ff;
	reg  [2:0]             state_ff;
	reg  [2:0]             nxt_state;
	reg                    strobe_d_ff;
	reg                    srcclk_d_ff;
	reg  [7:0]             edge_cnt_ff;
	reg                    cc1_ff;
	reg                    nxt_cc1;
	reg                    cc2_ff;
	reg                    nxt_cc2;
	reg                    ack_ff;
	reg                    nxt_ack;
	reg                    halt_ff;
	reg                    nxt_halt;
	reg                    hio_hit;
	reg  [15:0]            word_ff;
	reg                    word_ld;
	reg  [31:0]            rdata;
	reg                    clkfwd_ff;
	reg                    rstfwd_ff;

	// ==================================================
	// cable inputs pass two flops before any logic
	assign raw_pins = {source_clock_1mhz_in, control_strobe_in, func_code_bit0_in,
		func_code_bit1_in, func_code_bit2_in, processor_addr_in, reset_io_in};

	pin_sync #(
		.W (`SYNC_WIDTH)
	) u_sync (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.async_in (raw_pins),
		.sync_out (sync_pins)
	);

	assign srcclk_s = sync_pins[8];
	assign strobe_s = sync_pins[7];
	assign func_s   = sync_pins[6:4];
	assign addr_s   = sync_pins[3:1];
	assign rio_s    = sync_pins[0];
	assign own_addr = ctrl_ff[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];

	// ==================================================
	// instruction decode
	func_decode u_dec (
		.func_in     (func_s),
		.addr_in     (addr_s),
		.own_addr_in (own_addr),
		.irq_in      (interrupt_request_out),
		.start_out   (is_start),
		.test_out    (is_test),
		.tdev_out    (is_tdev),
		.halt_out    (is_halt),
		.ack_out     (is_ack),
		.claim_out   (claim)
	);

	// ==================================================
	// forwarded clock and reset toward the controllers
	// resampled copy, delayed by the synchroniser
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			clkfwd_ff   <= 1'b0;
			rstfwd_ff   <= 1'b0;
			srcclk_d_ff <= 1'b0;
			edge_cnt_ff <= 8'h00;
		end else begin
			clkfwd_ff   <= srcclk_s;
			srcclk_d_ff <= srcclk_s;
			rstfwd_ff   <= rio_s;
			// rising edges counted so software can see the clock alive
			if (srcclk_s & ~srcclk_d_ff) begin
				edge_cnt_ff <= edge_cnt_ff + 8'h01;
			end
		end
	end

	assign ctrl_clock_out = clkfwd_ff;
	assign ctrl_reset_out = rstfwd_ff;

	// ==================================================
	// sequencer next state
	always @* begin
		nxt_state = state_ff;
		nxt_cc1   = cc1_ff;
		nxt_cc2   = cc2_ff;
		nxt_ack   = ack_ff;
		nxt_halt  = halt_ff;
		word_ld   = 1'b0;
		hio_hit   = 1'b0;
		case (state_ff)
			`ST_IDLE: begin
				nxt_cc1 = 1'b0;
				nxt_cc2 = 1'b0;
				if (strobe_s & ~strobe_d_ff) begin
					nxt_ack  = is_ack;
					nxt_halt = is_halt;
					if (!claim) begin
						// last on chain answers itself, codes false
						if (ctrl_ff[`CTRL_LAST_BIT]) begin
							nxt_state = `ST_SETTLE;
						end else begin
							nxt_state = `ST_PASS;
						end
					end else if ((is_start | is_test | is_tdev) & partial_cond_in) begin
						nxt_cc2   = 1'b1;
						nxt_state = `ST_SETTLE;
					end else if ((is_halt | is_ack) & service_active_in) begin
						nxt_state = `ST_TERM;
					end else if (is_ack) begin
						nxt_state = `ST_CTRL;
					end else begin
						nxt_state = `ST_MEMRD;
					end
				end
			end
			`ST_PASS: begin
				if (!strobe_s) begin
					nxt_state = `ST_IDLE;
				end
			end
			`ST_TERM: begin
				if (!service_active_in) begin
					nxt_state = ack_ff ? `ST_CTRL : `ST_MEMRD;
				end
			end
			`ST_MEMRD: begin
				if (mem_rd_done_in) begin
					if (mem_parity_err_in) begin
						nxt_state = `ST_SETTLE;
					end else begin
						nxt_state = `ST_CTRL;
					end
				end
			end
			`ST_CTRL: begin
				if (ctrl_cc_valid_in) begin
					if (ack_ff) begin
						// pass through, clear two on unusual end
						nxt_cc1 = data_order_request_in;
						nxt_cc2 = in_out_request_in
							& ~(dc_addr_match_in & own_ff[`OWN_UNUSUAL]);
						word_ld = 1'b1;
						nxt_state = `ST_MEMWR;
					end else begin
						nxt_cc1 = data_order_request_in;
						nxt_cc2 = in_out_request_in;
						hio_hit = halt_ff & dc_addr_match_in;
						// proceed after codes unless a write follows
						nxt_state = ctrl_ff[`CTRL_WB_BIT] ? `ST_MEMWR : `ST_SETTLE;
					end
				end
			end
			`ST_MEMWR: begin
				// wait for address release of the last request
				if (mem_release_in) begin
					nxt_state = `ST_SETTLE;
				end
			end
			`ST_SETTLE: begin
				// codes stand one cycle before proceed
				nxt_state = `ST_PROCEED;
			end
			`ST_PROCEED: begin
				if (!strobe_s) begin
					nxt_state = `ST_IDLE;
				end
			end
			default: begin
				nxt_state = `ST_IDLE;
			end
		endcase
	end

	// ==================================================
	// sequencer registers
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff    <= `ST_IDLE;
			cc1_ff      <= 1'b0;
			cc2_ff      <= 1'b0;
			ack_ff      <= 1'b0;
			halt_ff     <= 1'b0;
			strobe_d_ff <= 1'b0;
			word_ff     <= 16'h0000;
		end else begin
			strobe_d_ff <= strobe_s;
			if (rio_s) begin
				state_ff <= `ST_IDLE;
				cc1_ff   <= 1'b0;
				cc2_ff   <= 1'b0;
				ack_ff   <= 1'b0;
				halt_ff  <= 1'b0;
			end else begin
				state_ff <= nxt_state;
				cc1_ff   <= nxt_cc1;
				cc2_ff   <= nxt_cc2;
				ack_ff   <= nxt_ack;
				halt_ff  <= nxt_halt;
			end
			// controller status low, own status high
			// top three word bits are zero
			if (word_ld) begin
				word_ff <= {`OWN_ZERO_PAD, own_ff, dc_status_in};
			end
		end
	end

	// ==================================================
	// cable and service outputs
	// proceed tied to the sequencer, released by strobe fall
	assign proceed_out         = (state_ff == `ST_PROCEED);
	// codes driven from settle until strobe drop
	assign cond_code_oe_out    = (state_ff == `ST_SETTLE) | (state_ff == `ST_PROCEED);
	assign cond_code_one_n_out = cc1_ff;
	assign cond_code_two_n_out = cc2_ff;
	assign strobe_pass_out     = (state_ff == `ST_PASS) & strobe_s;
	assign end_service_out     = (state_ff == `ST_TERM);
	assign ctrl_req_out        = (state_ff == `ST_CTRL);
	assign mem_rd_req_out      = (state_ff == `ST_MEMRD);
	assign mem_wr_req_out      = (state_ff == `ST_MEMWR);
	assign status_word_out     = word_ff;
	// request follows controllers, dropped while acknowledging
	assign interrupt_request_out = dc_int_req_in
		& ~(ack_ff & (state_ff != `ST_IDLE) & (state_ff != `ST_PASS));

	// ==================================================
	// own sticky status bits
	// incorrect length from either source
	assign set_ev[`OWN_INC_LEN]  = inc_len_status_ev_in | inc_len_buffer_ev_in;
	assign set_ev[`OWN_XMIT_ERR] = xmit_err_ev_in;
	// zero count, input needs the flag
	assign set_ev[`OWN_ZERO_CNT] = (ctrl_ff[`CTRL_IZC_BIT] & zero_cnt_in_ev_in)
		| zero_cnt_out_ev_in;
	assign set_ev[`OWN_CHAN_END] = ctrl_ff[`CTRL_ICE_BIT] & chan_end_ev_in;
	// unusual end on channel end or halt order
	assign set_ev[`OWN_UNUSUAL]  = ctrl_ff[`CTRL_IUE_BIT]
		& (chan_end_ev_in | halt_terminal_ev_in);

	// halt with matching controller clears the three interrupt bits
	assign hio_clr  = {hio_hit, hio_hit, hio_hit, 1'b0, 1'b0};
	assign clr_bits = (clr_wr ? pwdata_in[`STAT_BITS_MSB:`STAT_BITS_LSB]
		: {`OWN_WIDTH{1'b0}}) | hio_clr;

	// set wins over every clear
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			own_ff <= {`OWN_WIDTH{1'b0}};
		end else if (rio_s) begin
			own_ff <= set_ev;
		end else begin
			own_ff <= (own_ff & ~clr_bits) | set_ev;
		end
	end

	// ==================================================
	// apb slave, zero wait states
	assign addr_ok = (paddr_in == `REG_CTRL_ADDR) | (paddr_in == `REG_STATUS_ADDR)
		| (paddr_in == `REG_CLEAR_ADDR) | (paddr_in == `REG_WORD_ADDR);
	assign wr_en   = psel_in & penable_in & pwrite_in;
	assign rd_en   = psel_in & ~pwrite_in;
	assign clr_wr  = wr_en & (paddr_in == `REG_CLEAR_ADDR);

	// control register, software steers flags and chain position
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_ff <= `CTRL_RESET;
		end else if (wr_en & (paddr_in == `REG_CTRL_ADDR)) begin
			ctrl_ff <= pwdata_in[`CTRL_WIDTH-1:0];
		end
	end

	// read mux, unmapped reads give zero
	always @* begin
		rdata = `ZERO32;
		case (paddr_in)
			`REG_CTRL_ADDR: begin
				rdata[`CTRL_WIDTH-1:0] = ctrl_ff;
			end
			`REG_STATUS_ADDR: begin
				rdata[`STAT_BITS_MSB:`STAT_BITS_LSB]   = own_ff;
				rdata[`STAT_PR_BIT]                    = proceed_out;
				rdata[`STAT_CC1_BIT]                   = cc1_ff;
				rdata[`STAT_CC2_BIT]                   = cc2_ff;
				rdata[`STAT_STATE_MSB:`STAT_STATE_LSB] = state_ff;
				rdata[`STAT_EDGE_MSB:`STAT_EDGE_LSB]   = edge_cnt_ff;
			end
			`REG_WORD_ADDR: begin
				rdata[15:0] = word_ff;
			end
			default: begin
				rdata = `ZERO32;
			end
		endcase
	end

	assign prdata_out  = rd_en ? rdata : `ZERO32;
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~addr_ok;
endmodule

// ===== selector_io_processor_sva.sv
// assertion checker for the selector processor cpu port
`timescale 1ns/1ps
`include "io_processor_unit_defines.vh"
module selector_io_processor_sva (
	input wire        clk_in,
	input wire        rst_in,
	input wire        psel_in,
	input wire        penable_in,
	input wire [11:0] paddr_in,
	input wire        pslverr_out,
	input wire        source_clock_1mhz_in,
	input wire        control_strobe_in,
	input wire        reset_io_in,
	input wire        dc_int_req_in,
	input wire        interrupt_request_out,
	input wire        cond_code_one_n_out,
	input wire        cond_code_two_n_out,
	input wire        cond_code_oe_out,
	input wire        proceed_out,
	input wire        strobe_pass_out,
	input wire        ctrl_clock_out,
	input wire        ctrl_reset_out,
	input wire [15:0] status_word_out
);
	logic [1:0] warm_ff;
	// ==========
	// edges since reset, so delayed copies are only compared once filled
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			warm_ff <= 2'h0;
		end else if (warm_ff != 2'h3) begin
			warm_ff <= warm_ff + 2'h1;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_clock_fwd: assert property (warm_ff == 2'h3 |->
		ctrl_clock_out == $past(source_clock_1mhz_in, 3)) else $error("controller clock lags wrongly");
	a_reset_fwd: assert property (warm_ff == 2'h3 |->
		ctrl_reset_out == $past(reset_io_in, 3)) else $error("controller reset lags wrongly");
	a_irq_cause: assert property (interrupt_request_out |-> dc_int_req_in)
		else $error("interrupt request without controller request");
	a_word_top: assert property (status_word_out[15:13] == 3'h0)
		else $error("status word top bits not zero");
	a_pass_quiet: assert property (strobe_pass_out |-> !proceed_out && !cond_code_oe_out)
		else $error("lines driven while strobe passed on");
	a_codes_driven: assert property (proceed_out |-> cond_code_oe_out)
		else $error("proceed without driven condition codes");
	a_codes_steady: assert property (proceed_out && $past(proceed_out) |->
		$stable({cond_code_one_n_out, cond_code_two_n_out})) else $error("codes moved under proceed");
	a_proceed_drop: assert property (proceed_out && !control_strobe_in |->
		##[1:5] !proceed_out) else $error("proceed stayed after strobe dropped");
	a_proceed_rise: assert property ($rose(proceed_out) |-> control_strobe_in)
		else $error("proceed rose without strobe");
	a_map_err: assert property (psel_in && penable_in |-> pslverr_out == !(paddr_in inside
		{`REG_CTRL_ADDR, `REG_STATUS_ADDR, `REG_CLEAR_ADDR, `REG_WORD_ADDR}))
		else $error("slave error does not match the address map");
endmodule
bind selector_io_processor selector_io_processor_sva i_sva (.clk_in(clk_in), .rst_in(rst_in),
	.psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .pslverr_out(pslverr_out),
	.source_clock_1mhz_in(source_clock_1mhz_in), .control_strobe_in(control_strobe_in),
	.reset_io_in(reset_io_in), .dc_int_req_in(dc_int_req_in),
	.interrupt_request_out(interrupt_request_out), .cond_code_one_n_out(cond_code_one_n_out),
	.cond_code_two_n_out(cond_code_two_n_out), .cond_code_oe_out(cond_code_oe_out),
	.proceed_out(proceed_out), .strobe_pass_out(strobe_pass_out),
	.ctrl_clock_out(ctrl_clock_out), .ctrl_reset_out(ctrl_reset_out),
	.status_word_out(status_word_out));

// ===== service_partner.sv
// controller and memory responder model for the selector processor bench
`timescale 1ns/1ps
module service_partner #(
	parameter [7:0] STATUS = 8'hA5
) (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        mem_rd_req_in,
	input  wire        ctrl_req_in,
	input  wire        mem_wr_req_in,
	input  wire        parity_cfg_in,
	input  wire  [1:0] cc_cfg_in,
	input  wire  [3:0] delay_cfg_in,
	output logic       mem_rd_done_out,
	output wire        mem_parity_err_out,
	output logic       ctrl_cc_valid_out,
	output wire        data_order_request_out,
	output wire        in_out_request_out,
	output wire        dc_addr_match_out,
	output wire  [7:0] dc_status_out,
	output logic       mem_release_out
);
	wire  [2:0] req = {mem_rd_req_in, ctrl_req_in, mem_wr_req_in};
	logic [2:0] served_ff;
	logic [3:0] wait_ff;
	// ==========
	// qualified lines show the inverse outside their valid cycle, never a stale copy
	assign mem_parity_err_out     = mem_rd_done_out ? parity_cfg_in : !parity_cfg_in;
	assign data_order_request_out = ctrl_cc_valid_out ? cc_cfg_in[1] : !cc_cfg_in[1];
	assign in_out_request_out     = ctrl_cc_valid_out ? cc_cfg_in[0] : !cc_cfg_in[0];
	assign dc_addr_match_out      = ctrl_cc_valid_out;
	assign dc_status_out          = ctrl_cc_valid_out ? STATUS : ~STATUS;
	// answer each new request once, after a chosen delay
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			served_ff <= 3'h0;
			wait_ff <= 4'h0;
			mem_rd_done_out <= 1'b0;
			ctrl_cc_valid_out <= 1'b0;
			mem_release_out <= 1'b0;
		end else begin
			mem_rd_done_out <= 1'b0;
			ctrl_cc_valid_out <= 1'b0;
			mem_release_out <= 1'b0;
			if (req == 3'h0) begin
				served_ff <= 3'h0;
				wait_ff <= 4'h0;
			end else if (req != served_ff && wait_ff == delay_cfg_in) begin
				mem_rd_done_out <= req[2];
				ctrl_cc_valid_out <= req[1];
				mem_release_out <= req[0];
				served_ff <= req;
				wait_ff <= 4'h0;
			end else if (req != served_ff) begin
				wait_ff <= wait_ff + 4'h1;
			end
		end
	end
endmodule

// ===== selector_io_processor_tb.sv
// self-checking bench for the selector processor cpu port
`timescale 1ns/1ps
`include "io_processor_unit_defines.vh"
module selector_io_processor_tb;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        src_clk = 1'b0, strobe = 1'b0, reset_io = 1'b0;
	logic [2:0]  func = 3'h0, cpu_addr = 3'h0;
	logic        dc_int_req = 1'b0, service_active = 1'b0, partial_cond = 1'b0;
	logic        parity_cfg = 1'b0, seen_end = 1'b0, irq_at_pr = 1'b0, rerr;
	logic [1:0]  cc_cfg = 2'h0;
	logic [3:0]  delay_cfg = 4'h0;
	logic [6:0]  ev = 7'h00;
	logic [31:0] rdata;
	int          num_errors = 0;
	int          tests_run = 0;
	wire  [31:0] prdata;
	wire  [15:0] status_word;
	wire  [7:0]  dc_status;
	wire         pready, pslverr, irq, cc1, cc2, cc_oe, proceed, strobe_pass, ctrl_clock;
	wire         ctrl_reset, end_service, ctrl_req, cc_valid, data_order_request, in_out_request, addr_match;
	wire         mem_rd_req, rd_done, parity_err, mem_wr_req, mem_release;
	// ==========
	// clocks: the cpu source clock runs free with its own phase
	always #20 clk_in = ~clk_in;
	initial begin
		#7;
		forever #160 src_clk = ~src_clk;
	end
	// service ends when the port asks for it
	always @(posedge clk_in) begin
		if (end_service === 1'b1) begin
			seen_end <= 1'b1;
			service_active <= 1'b0;
		end
	end
	selector_io_processor i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.source_clock_1mhz_in(src_clk), .control_strobe_in(strobe), .func_code_bit0_in(func[2]),
		.func_code_bit1_in(func[1]), .func_code_bit2_in(func[0]), .processor_addr_in(cpu_addr),
		.reset_io_in(reset_io), .interrupt_request_out(irq), .cond_code_one_n_out(cc1),
		.cond_code_two_n_out(cc2), .cond_code_oe_out(cc_oe), .proceed_out(proceed),
		.strobe_pass_out(strobe_pass), .ctrl_clock_out(ctrl_clock), .ctrl_reset_out(ctrl_reset),
		.dc_int_req_in(dc_int_req), .service_active_in(service_active),
		.partial_cond_in(partial_cond), .end_service_out(end_service), .ctrl_req_out(ctrl_req),
		.ctrl_cc_valid_in(cc_valid), .data_order_request_in(data_order_request), .in_out_request_in(in_out_request),
		.dc_addr_match_in(addr_match), .dc_status_in(dc_status), .mem_rd_req_out(mem_rd_req),
		.mem_rd_done_in(rd_done), .mem_parity_err_in(parity_err), .mem_wr_req_out(mem_wr_req),
		.mem_release_in(mem_release), .status_word_out(status_word),
		.inc_len_status_ev_in(ev[0]), .inc_len_buffer_ev_in(ev[1]), .xmit_err_ev_in(ev[2]),
		.zero_cnt_in_ev_in(ev[3]), .zero_cnt_out_ev_in(ev[4]), .chan_end_ev_in(ev[5]),
		.halt_terminal_ev_in(ev[6]));
	service_partner i_partner (.clk_in(clk_in), .rst_in(rst_in), .mem_rd_req_in(mem_rd_req),
		.ctrl_req_in(ctrl_req), .mem_wr_req_in(mem_wr_req), .parity_cfg_in(parity_cfg),
		.cc_cfg_in(cc_cfg), .delay_cfg_in(delay_cfg), .mem_rd_done_out(rd_done),
		.mem_parity_err_out(parity_err), .ctrl_cc_valid_out(cc_valid),
		.data_order_request_out(data_order_request), .in_out_request_out(in_out_request), .dc_addr_match_out(addr_match),
		.dc_status_out(dc_status), .mem_release_out(mem_release));
	// ==========
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic timed_out;
		num_errors++;
		wrap_up();
	endtask
	// apb transfer: held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// data and response taken at the very edge that saw pready
		rdata = prdata;
		rerr = pslverr;
		if (pready !== 1'b1) timed_out();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic own(input logic [4:0] e);
		apb(1'b0, `REG_STATUS_ADDR, 32'h0000_0000);
		check({27'h0, rdata[4:0]}, {27'h0, e});
	endtask
	task automatic pulse(input int k);
		@(posedge clk_in);
		ev[k] <= 1'b1;
		@(posedge clk_in);
		ev <= 7'h00;
	endtask
	// cpu instruction: function and address settle before the strobe rises
	task automatic cpu_instr(input logic [2:0] fn, input logic [2:0] ad, input logic exp_pass,
		input logic [1:0] exp_cc);
		int n;
		@(posedge clk_in);
		func <= fn;
		cpu_addr <= ad;
		repeat (4) @(posedge clk_in);
		strobe <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (proceed !== 1'b1 && strobe_pass !== 1'b1 && n < 300);
		if (n >= 300) timed_out();
		check({31'h0, strobe_pass}, {31'h0, exp_pass});
		if (!exp_pass) check({30'h0, cc1, cc2}, {30'h0, exp_cc});
		irq_at_pr = irq;
		@(posedge clk_in);
		strobe <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while ((proceed !== 1'b0 || strobe_pass !== 1'b0) && n < 20);
		check({31'h0, proceed}, 32'h0000_0000);
		repeat (2) @(posedge clk_in);
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		apb(1'b0, `REG_CTRL_ADDR, 32'h0000_0000);
		check(rdata, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0000_0000);
		check({31'h0, rerr}, 32'h0000_0001);
		apb(1'b1, `REG_CTRL_ADDR, 32'h0000_0500);
		cpu_instr(`FN_ACK_INT, 3'h5, 1'b1, 2'h0);
		cpu_instr(`FN_TEST, 3'h3, 1'b1, 2'h0);
		apb(1'b1, `REG_CTRL_ADDR, 32'h0000_0501);
		cpu_instr(`FN_TEST, 3'h3, 1'b0, 2'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `REG_CTRL_ADDR, 32'h0000_0500 | {27'h0, i[0], 4'h0});
			cc_cfg <= i[1:0];
			delay_cfg <= 4'(i * 3);
			service_active <= (i == 3);
			cpu_instr(3'(i), 3'h5, 1'b0, i[1:0]);
		end
		check({31'h0, seen_end}, 32'h0000_0001);
		parity_cfg <= 1'b1;
		cpu_instr(`FN_HALT, 3'h5, 1'b0, 2'h0);
		parity_cfg <= 1'b0;
		partial_cond <= 1'b1;
		cpu_instr(`FN_START, 3'h5, 1'b0, 2'h1);
		partial_cond <= 1'b0;
		apb(1'b1, `REG_CTRL_ADDR, 32'h0000_0500);
		pulse(3);
		pulse(5);
		own(5'h00);
		pulse(4);
		own(5'h04);
		apb(1'b1, `REG_CTRL_ADDR, 32'h0000_050E);
		pulse(5);
		pulse(1);
		pulse(2);
		own(5'h1F);
		dc_int_req <= 1'b1;
		cc_cfg <= 2'h3;
		@(posedge clk_in);
		check({31'h0, irq}, 32'h0000_0001);
		cpu_instr(`FN_ACK_INT, 3'h0, 1'b0, 2'h2);
		check({31'h0, irq_at_pr}, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0001);
		check({16'h0, status_word}, 32'h0000_1FA5);
		apb(1'b0, `REG_WORD_ADDR, 32'h0000_0000);
		check(rdata, 32'h0000_1FA5);
		dc_int_req <= 1'b0;
		cc_cfg <= 2'h0;
		cpu_instr(`FN_HALT, 3'h5, 1'b0, 2'h0);
		pulse(6);
		own(5'h13);
		apb(1'b1, `REG_CLEAR_ADDR, 32'h0000_0013);
		pulse(0);
		own(5'h01);
		@(posedge clk_in);
		reset_io <= 1'b1;
		repeat (6) @(posedge clk_in);
		check({31'h0, ctrl_reset}, 32'h0000_0001);
		reset_io <= 1'b0;
		repeat (6) @(posedge clk_in);
		own(5'h00);
		cc_cfg <= 2'h2;
		cpu_instr(`FN_TEST_DEV, 3'h5, 1'b0, 2'h2);
		wrap_up();
	end
endmodule
